// *** src/tlip_pkg.sv ***
// Purpose: Shared constants and types of the two-level interrupt unit
// Assumes: 32-bit AHB-Lite register bus, 21-bit program counter
// Notes:   Register offsets are byte addresses of aligned words

package tlip_pkg;

    // ------------------------------------------------------------
    // Vectors
    // ------------------------------------------------------------
    localparam int unsigned     PC_W     = 21;
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h0_0008;
    localparam logic [PC_W-1:0] VEC_LOW  = 21'h0_0018;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RESET_CTRL = 8'h00;
    localparam logic [7:0] OFF_MAIN_CTRL  = 8'h04;
    localparam logic [7:0] OFF_FLAGS      = 8'h08;
    localparam logic [7:0] OFF_ENABLES    = 8'h0C;
    localparam logic [7:0] OFF_PRIORITY   = 8'h10;
    localparam logic [7:0] OFF_PERIPH     = 8'h14;
    localparam logic [7:0] OFF_STATUS     = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_PRIO_MODE = 7;
    localparam int unsigned BIT_GATE_HIGH = 7;
    localparam int unsigned BIT_GATE_LOW  = 6;
    localparam int unsigned BIT_ST_HIGHEL = 4;
    localparam int unsigned BIT_ST_LOWEL  = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_PRIORITY = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SVC_IDLE = 4'b0001,
        SVC_LOW  = 4'b0010,
        SVC_HIGH = 4'b0100,
        SVC_NEST = 4'b1000
    } tlip_svc_e;

    typedef struct packed {
        logic            pcLoad;
        logic            stackPush;
        logic [PC_W-1:0] target;
        logic [PC_W-1:0] retAddr;
    } tlip_vec_s;

endpackage

// *** src/tlip_pin_sync.sv ***
// Purpose: Synchronise event pins and turn their edges into pulses
// Assumes: Pins are asynchronous to clk
// Notes:   Pins reset low, so a pin high at release gives one rise

`timescale 1ns/1ps
`default_nettype none

module tlip_pin_sync
    import tlip_pkg::*;
#(
    parameter int unsigned W        = 4,
    parameter logic [W-1:0] ANY_EDGE = '0
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Pins
    input  wire logic [W-1:0] pinIn,
    // One-cycle events
    output logic      [W-1:0] pinEvent
);

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic [2:0] sync_ff;

            // Stage 0 feeds only stage 1; edges come from 1 and 2
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    sync_ff <= 3'h0;
                else
                    sync_ff <= {sync_ff[1:0], pinIn[g]};
            end

            // Change-type lines fire on either edge, others on rise
            assign pinEvent[g] = ANY_EDGE[g] ? (sync_ff[2] ^ sync_ff[1]) // RQ17
                                             : (sync_ff[1] & ~sync_ff[2]);
        end
    endgenerate

endmodule

`default_nettype wire

// *** src/tlip_ctrl.sv ***
// Purpose: Two-level interrupt controller with AHB-Lite registers
// Assumes: clk is the instruction clock; core flags instruction edges
// Notes:   Zero-wait bus slave, every response OKAY
//
// How it works
// RQ1 - High vector 0008h, low vector 0018h
// RQ2 - High request may pre-empt low service
// RQ3 - Each source: flag, enable, priority bit
// RQ4 - Reset control bit 7 turns priority on
// RQ5 - Priority mode: bit 7 gates high sources
// RQ6 - Priority mode: bit 6 gates low sources
// RQ7 - Flag, enable, gate set: vector at once
// RQ8 - Clear source enable blocks its vector
// RQ9 - Priority off after reset; priority bits ignored
// RQ10 - Compatibility: bit 6 peripherals, bit 7 all
// RQ11 - Compatibility mode always vectors to 0008h
// RQ12 - Accepting clears the serviced level's gate
// RQ13 - No low service during high service
// RQ14 - Push return address, load vector into PC
// RQ15 - Software clears flags before re-enabling gates
// RQ16 - Return sets the serviced level's gate again
// RQ17 - Pin events vector in three-four cycles
// RQ18 - Events set flags whatever the enables
// RQ19 - Software avoids memory-to-memory moves here
// RQ20 - High gate clear disables both levels
// RQ21 - Both levels eligible: high goes first
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module tlip_ctrl
    import tlip_pkg::*;
#(
    parameter int unsigned  N        = 8,
    parameter int unsigned  EXT_W    = 4,
    parameter logic [EXT_W-1:0] PIN_ANY_EDGE = 4'b1000,
    parameter logic [N-1:0] PERIPH_RST = 8'hF0
)
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic      [31:0]     hrdata,
    // Interrupt sources
    input  wire logic [N-1:0]    srcEvent,
    input  wire logic [EXT_W-1:0] extPin,
    // Core sequencer
    input  wire logic            instrBoundary,
    input  wire logic [PC_W-1:0] nextPc,
    input  wire logic            serviceReturn,
    output tlip_vec_s            vecOut,
    output logic                 priority_mode_enable
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [N-1:0]     flag_ff;
    logic [N-1:0]     enable_ff;
    logic [N-1:0]     prio_ff;
    logic [N-1:0]     periph_ff;
    logic             prioMode_ff;
    logic             gateHi_ff;
    logic             gateLo_ff;
    tlip_svc_e        svc_ff;
    tlip_svc_e        nxt_svc;
    tlip_vec_s        vec_ff;
    logic             wrPend_ff;
    logic [7:0]       wrAddr_ff;
    logic [31:0]      hrdata_ff;
    logic [31:0]      rdData;
    logic [EXT_W-1:0] pinEvent;
    logic [N-1:0]     srcAll;
    logic [N-1:0]     armed;
    logic             addrPhase;
    logic             highEl;
    logic             lowEl;
    logic             inHigh;
    logic             highTake;
    logic             lowTake;
    logic             retHi;
    logic             retLo;

    // ------------------------------------------------------------
    // Pin events
    // ------------------------------------------------------------
    tlip_pin_sync #(.W(EXT_W), .ANY_EDGE(PIN_ANY_EDGE)) u_pin_sync (
        .clk(clk), .rst_n(rst_n), .pinIn(extPin), .pinEvent(pinEvent)
    );

    assign srcAll = srcEvent | N'(pinEvent);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    assign addrPhase = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
        end
        else
        begin
            wrPend_ff <= addrPhase & hwrite & (haddr[31:8] == 24'h00_0000);
            wrAddr_ff <= haddr[7:0];
        end
    end

    // Unmapped words read as zero
    always_comb
    begin
        rdData = RST_ZERO;
        if (haddr[31:8] != 24'h00_0000)
            rdData = RST_ZERO;
        else if (haddr[7:0] == OFF_RESET_CTRL)
            rdData[BIT_PRIO_MODE] = prioMode_ff;
        else if (haddr[7:0] == OFF_MAIN_CTRL)
        begin
            rdData[BIT_GATE_HIGH] = gateHi_ff;
            rdData[BIT_GATE_LOW]  = gateLo_ff;
        end
        else if (haddr[7:0] == OFF_FLAGS)
            rdData[N-1:0] = flag_ff;
        else if (haddr[7:0] == OFF_ENABLES)
            rdData[N-1:0] = enable_ff;
        else if (haddr[7:0] == OFF_PRIORITY)
            rdData[N-1:0] = prio_ff;
        else if (haddr[7:0] == OFF_PERIPH)
            rdData[N-1:0] = periph_ff;
        else if (haddr[7:0] == OFF_STATUS)
        begin
            rdData[3:0]           = svc_ff;
            rdData[BIT_ST_HIGHEL] = highEl;
            rdData[BIT_ST_LOWEL]  = lowEl;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hrdata_ff <= RST_ZERO;
        else if (addrPhase && !hwrite)
            hrdata_ff <= rdData;
    end

    // ------------------------------------------------------------
    // Per-source registers and priority mode bit
    // ------------------------------------------------------------
    // An event in the clearing cycle survives the write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_ff <= N'(RST_ZERO);
        else if (wrPend_ff && wrAddr_ff == OFF_FLAGS)
            flag_ff <= hwdata[N-1:0] | srcAll; // RQ18 RQ3
        else
            flag_ff <= flag_ff | srcAll; // RQ18
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_ff <= N'(RST_ZERO);
            prio_ff   <= N'(RST_PRIORITY);
            periph_ff <= PERIPH_RST;
        end
        else if (wrPend_ff)
        begin
            if (wrAddr_ff == OFF_ENABLES)
                enable_ff <= hwdata[N-1:0]; // RQ3
            if (wrAddr_ff == OFF_PRIORITY)
                prio_ff <= hwdata[N-1:0]; // RQ3
            if (wrAddr_ff == OFF_PERIPH)
                periph_ff <= hwdata[N-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prioMode_ff <= 1'b0; // RQ9
        else if (wrPend_ff && wrAddr_ff == OFF_RESET_CTRL)
            prioMode_ff <= hwdata[BIT_PRIO_MODE]; // RQ4
    end

    assign priority_mode_enable = prioMode_ff;

    // ------------------------------------------------------------
    // Request decision
    // ------------------------------------------------------------
    assign armed  = flag_ff & enable_ff; // RQ8
    assign inHigh = (svc_ff == SVC_HIGH) || (svc_ff == SVC_NEST);

    // Compatibility mode ignores priority bits entirely
    always_comb
    begin
        if (prioMode_ff)
        begin
            highEl = gateHi_ff & (|(armed & prio_ff)); // RQ5
            lowEl  = gateHi_ff & gateLo_ff & (|(armed & ~prio_ff)); // RQ6 RQ20
        end
        else
        begin
            highEl = gateHi_ff & (|(armed & (~periph_ff | {N{gateLo_ff}}))); // RQ10 RQ9
            lowEl  = 1'b0;
        end
    end
    assign highTake = instrBoundary & highEl & (~prioMode_ff | ~inHigh); // RQ7 RQ2
    assign lowTake  = instrBoundary & lowEl & ~highTake & (svc_ff == SVC_IDLE); // RQ13 RQ21
    assign retHi = serviceReturn & (~prioMode_ff | inHigh);
    assign retLo = serviceReturn & prioMode_ff & (svc_ff == SVC_LOW);

    // ------------------------------------------------------------
    // Service state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_svc = svc_ff;
        case (svc_ff)
            SVC_IDLE:
                if (highTake)
                    nxt_svc = SVC_HIGH;
                else if (lowTake)
                    nxt_svc = SVC_LOW;
            SVC_LOW:
                if (highTake)
                    nxt_svc = SVC_NEST; // RQ2
                else if (serviceReturn)
                    nxt_svc = SVC_IDLE;
            SVC_HIGH:
                if (serviceReturn && !highTake)
                    nxt_svc = SVC_IDLE;
            SVC_NEST:
                if (serviceReturn)
                    nxt_svc = SVC_LOW;
            default:
                nxt_svc = SVC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            svc_ff <= SVC_IDLE;
        else
            svc_ff <= nxt_svc;
    end

    // ------------------------------------------------------------
    // Level gates
    // ------------------------------------------------------------
    // Hardware entry and return take precedence over a bus write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gateHi_ff <= 1'b0;
            gateLo_ff <= 1'b0;
        end
        else
        begin
            if (highTake)
                gateHi_ff <= 1'b0; // RQ12
            else if (retHi)
                gateHi_ff <= 1'b1; // RQ16
            else if (wrPend_ff && wrAddr_ff == OFF_MAIN_CTRL)
                gateHi_ff <= hwdata[BIT_GATE_HIGH];
            if (lowTake)
                gateLo_ff <= 1'b0; // RQ12
            else if (retLo)
                gateLo_ff <= 1'b1; // RQ16
            else if (wrPend_ff && wrAddr_ff == OFF_MAIN_CTRL)
                gateLo_ff <= hwdata[BIT_GATE_LOW];
        end
    end

    // ------------------------------------------------------------
    // Vector to core
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            vec_ff <= '0;
        else
        begin
            vec_ff.pcLoad    <= highTake | lowTake; // RQ14
            vec_ff.stackPush <= highTake | lowTake; // RQ14
            if (highTake)
                vec_ff.target <= VEC_HIGH; // RQ1 RQ11
            else if (lowTake)
                vec_ff.target <= VEC_LOW; // RQ1
            if (highTake || lowTake)
                vec_ff.retAddr <= nextPc; // RQ14
        end
    end
    assign vecOut = vec_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence takeHigh_s;
        highTake;
    endsequence
    sequence retFromHigh_s;
        serviceReturn && svc_ff == SVC_HIGH && !highTake;
    endsequence

    high_vec_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        takeHigh_s |=> vecOut.pcLoad && vecOut.target == VEC_HIGH)
        else $error("high vector not at high address");
    low_vec_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        lowTake |=> vecOut.pcLoad && vecOut.target == VEC_LOW)
        else $error("low vector not at low address");
    compat_one_vec_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
        vecOut.pcLoad && !$past(prioMode_ff) |-> vecOut.target == VEC_HIGH)
        else $error("compatibility mode used low vector");
    entry_gate_clr_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
        takeHigh_s ##1 !highTake |-> !gateHi_ff && vecOut.pcLoad)
        else $error("gate still set after entry");
    no_low_in_high_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
        inHigh && prioMode_ff |=> !(vecOut.pcLoad && vecOut.target == VEC_LOW))
        else $error("low vector during high service");
    preempt_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
        svc_ff == SVC_LOW && prioMode_ff && highEl && instrBoundary
        |=> svc_ff == SVC_NEST && vecOut.target == VEC_HIGH)
        else $error("high request did not pre-empt low service");
    return_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
        retFromHigh_s ##0 !(wrPend_ff && wrAddr_ff == OFF_MAIN_CTRL)
        |=> gateHi_ff && svc_ff == SVC_IDLE)
        else $error("return did not restore gate");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
        |srcAll |=> (flag_ff & $past(srcAll)) == $past(srcAll))
        else $error("event did not set its flag");
    enable_block_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        armed == '0 |=> !vecOut.pcLoad)
        else $error("vector without an enabled flag");
    high_first_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ21
        highEl && lowEl && instrBoundary && svc_ff == SVC_IDLE |-> highTake && !lowTake)
        else $error("low served before high");
    push_ret_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
        highTake || lowTake |=> vecOut.stackPush && vecOut.retAddr == $past(nextPc))
        else $error("return address not pushed");
    high_gate_all_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ20
        !gateHi_ff |=> !vecOut.pcLoad)
        else $error("vector with high gate clear");

endmodule

`default_nettype wire

// *** bench/tlip_core_model.sv ***
// Purpose: Behavioural core sequencer facing the interrupt unit
// Assumes: One clock; vector strobes last one cycle
// Notes:   slowMode drops every other boundary, like a two-cycle op

`timescale 1ns/1ps
`default_nettype none

module tlip_core_model
    import tlip_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Test control
    input  wire logic            slowMode,
    input  wire logic            retReq,
    // Interrupt unit side
    input  wire tlip_vec_s       vecOut,
    output logic                 instrBoundary,
    output logic      [PC_W-1:0] nextPc,
    output logic                 serviceReturn
);
    logic [PC_W-1:0] stack [$];
    logic            phase_ff;

    // A return with an empty stack is ignored, as a real core would trap
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nextPc        <= 21'h0_0100;
            phase_ff      <= 1'b0;
            serviceReturn <= 1'b0;
        end
        else
        begin
            phase_ff      <= ~phase_ff;
            serviceReturn <= retReq && stack.size() > 0;
            if (vecOut.pcLoad)
            begin
                stack.push_back(vecOut.retAddr);
                nextPc <= vecOut.target;
            end
            else if (retReq && stack.size() > 0)
                nextPc <= stack.pop_back();
            else if (instrBoundary)
                nextPc <= nextPc + 21'h0_0002;
        end
    end

    assign instrBoundary = !slowMode || phase_ff;

endmodule

`default_nettype wire

// *** bench/two_level_interrupt_priority_unit_test.sv ***
// Purpose: Self-checking bench of the two-level interrupt unit
// Assumes: Zero-wait AHB-Lite slave, vector strobe one cycle after take
// Notes:   Vectors are noted in expQ and checked by the monitor process

`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_priority_unit_test
    import tlip_pkg::*;
;
    logic            clk;
    logic            rst_n;
    logic            hsel;
    logic [31:0]     haddr;
    logic [1:0]      htrans;
    logic            hwrite;
    logic [31:0]     hwdata;
    logic            hreadyout;
    logic            hresp;
    logic [31:0]     hrdata;
    logic [7:0]      srcEvent;
    logic [3:0]      extPin;
    logic            instrBoundary;
    logic [PC_W-1:0] nextPc;
    logic [PC_W-1:0] lastPc;
    logic            serviceReturn;
    tlip_vec_s       vecOut;
    logic            prioMode;
    logic            slowMode;
    logic            retReq;
    logic [PC_W-1:0] expQ [$];
    int              err_count;
    int              check_count;

    tlip_ctrl tlip_ctrl_i (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .srcEvent(srcEvent), .extPin(extPin), .instrBoundary(instrBoundary),
        .nextPc(nextPc), .serviceReturn(serviceReturn), .vecOut(vecOut),
        .priority_mode_enable(prioMode)
    );

    tlip_core_model tlip_core_model_i (
        .clk(clk), .rst_n(rst_n), .slowMode(slowMode), .retReq(retReq),
        .vecOut(vecOut), .instrBoundary(instrBoundary), .nextPc(nextPc),
        .serviceReturn(serviceReturn)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic waitReady();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= a;
        waitReady();
        htrans <= 2'b00;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, {24'h00_0000, a}, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, {24'h00_0000, a}, 32'h0000_0000, q);
        check(q, exp);
    endtask

    task automatic pulse(input logic [7:0] m);
        srcEvent <= m;
        @(posedge clk);
        srcEvent <= 8'h00;
    endtask

    task automatic doReturn();
        retReq <= 1'b1;
        @(posedge clk);
        retReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic waitVec();
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (expQ.size() != 0)
        begin
            err_count++;
            end_of_test();
        end
        @(posedge clk);
    endtask

    // Any strobe with nothing noted is a wrong vector
    always @(posedge clk)
    begin
        lastPc <= nextPc;
        if (rst_n === 1'b1 && vecOut.pcLoad === 1'b1)
        begin
            check(32'(vecOut.stackPush), 32'h0000_0001);
            check(32'(vecOut.retAddr), 32'(lastPc));
            if (expQ.size() == 0)
                check(32'(vecOut.target), 32'hFFFF_FFFF);
            else
                check(32'(vecOut.target), 32'(expQ.pop_front()));
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] rnd;
        int          n;
        rst_n    = 1'b0;
        hsel     = 1'b0;
        haddr    = 32'h0000_0000;
        htrans   = 2'b00;
        hwrite   = 1'b0;
        hwdata   = 32'h0000_0000;
        srcEvent = 8'h00;
        extPin   = 4'h0;
        slowMode = 1'b0;
        retReq   = 1'b0;
        rnd      = $urandom(73030);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(32'(prioMode), 32'h0000_0000);
        rd(OFF_RESET_CTRL, 32'h0000_0000);
        rd(OFF_MAIN_CTRL, 32'h0000_0000);
        rd(OFF_PRIORITY, 32'h0000_00FF);
        rd(OFF_PERIPH, 32'h0000_00F0);
        bus(1'b0, 32'h0000_0100, 32'h0000_0000, rnd);
        check(rnd, 32'h0000_0000);
        rnd = $urandom;
        wr(OFF_ENABLES, rnd);
        rd(OFF_ENABLES, rnd & 32'h0000_00FF);
        // Compatibility mode: disabled source only raises its flag
        wr(OFF_ENABLES, 32'h0000_0001);
        pulse(8'h02);
        wr(OFF_MAIN_CTRL, 32'h0000_00C0);
        repeat (6) @(posedge clk);
        rd(OFF_FLAGS, 32'h0000_0002);
        wr(OFF_FLAGS, 32'h0000_0000);
        wr(OFF_PRIORITY, 32'h0000_0000);
        wr(OFF_ENABLES, 32'h0000_0011);
        wr(OFF_MAIN_CTRL, 32'h0000_0080);
        pulse(8'h10);
        repeat (6) @(posedge clk);
        expQ.push_back(VEC_HIGH);
        wr(OFF_MAIN_CTRL, 32'h0000_00C0);
        waitVec();
        rd(OFF_MAIN_CTRL, 32'h0000_0040);
        wr(OFF_FLAGS, 32'h0000_0000);
        doReturn();
        rd(OFF_MAIN_CTRL, 32'h0000_00C0);
        // Priority mode, slow core: both levels pending at once
        wr(OFF_MAIN_CTRL, 32'h0000_0000);
        wr(OFF_RESET_CTRL, 32'h0000_0080);
        @(posedge clk);
        check(32'(prioMode), 32'h0000_0001);
        wr(OFF_PRIORITY, 32'h0000_0001);
        slowMode <= 1'b1;
        pulse(8'h11);
        expQ.push_back(VEC_HIGH);
        wr(OFF_MAIN_CTRL, 32'h0000_00C0);
        waitVec();
        rd(OFF_MAIN_CTRL, 32'h0000_0040);
        wr(OFF_FLAGS, 32'h0000_0010);
        wr(OFF_MAIN_CTRL, 32'h0000_00C0);
        repeat (6) @(posedge clk);
        expQ.push_back(VEC_LOW);
        doReturn();
        waitVec();
        rd(OFF_MAIN_CTRL, 32'h0000_0080);
        wr(OFF_FLAGS, 32'h0000_0000);
        expQ.push_back(VEC_HIGH);
        pulse(8'h01);
        waitVec();
        wr(OFF_FLAGS, 32'h0000_0000);
        doReturn();
        doReturn();
        rd(OFF_MAIN_CTRL, 32'h0000_00C0);
        // High gate off blocks the low level too
        wr(OFF_MAIN_CTRL, 32'h0000_0040);
        pulse(8'h10);
        repeat (6) @(posedge clk);
        wr(OFF_FLAGS, 32'h0000_0000);
        // Pin event to vector strobe, prompt core
        slowMode <= 1'b0;
        wr(OFF_MAIN_CTRL, 32'h0000_0080);
        expQ.push_back(VEC_HIGH);
        extPin <= 4'b0001;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (vecOut.pcLoad !== 1'b1 && n < 12);
        check(32'(n >= 4 && n <= 5), 32'h0000_0001);
        waitVec();
        wr(OFF_FLAGS, 32'h0000_0000);
        doReturn();
        // Change-type pin, not enabled: both edges raise its flag
        extPin <= 4'b1001;
        repeat (4) @(posedge clk);
        rd(OFF_FLAGS, 32'h0000_0008);
        wr(OFF_FLAGS, 32'h0000_0000);
        extPin <= 4'b0001;
        repeat (4) @(posedge clk);
        rd(OFF_FLAGS, 32'h0000_0008);
        check(32'(expQ.size()), 32'h0000_0000);
        end_of_test();
    end

endmodule

`default_nettype wire
